// File: core/gpfc_pkg.sv
// package: constants for the two-pin function control block
package gpfc_pkg;
    localparam int unsigned CLK_HZ          = 20000000;
    localparam int unsigned SLOW_HZ         = 32768;
    // 32kHz tick divider, rounded down so the tick is never slower than the slow clock
    localparam int unsigned SLOW_DIV        = CLK_HZ / SLOW_HZ;
    localparam int unsigned NPINS           = 2;
    localparam int unsigned NDSP            = 8;
    // register offsets (word index on the plain port)
    localparam logic [3:0] OFS_PIN0_CFG     = 4'h0;
    localparam logic [3:0] OFS_PIN1_CFG     = 4'h1;
    localparam logic [3:0] OFS_DBTIME       = 4'h2;
    localparam logic [3:0] OFS_IRQ_STS      = 4'h3;
    localparam logic [3:0] OFS_PRIMARY_INTERRUPT_REQUEST_MASK    = 4'h4;
    localparam logic [3:0] OFS_SECONDARY_INTERRUPT_REQUEST_MASK    = 4'h5;
    localparam logic [3:0] OFS_SEQ_STS      = 4'h6;
    // pin configuration word fields
    localparam int unsigned FLD_FN_LO       = 0;
    localparam int unsigned FLD_DIR         = 8;
    localparam int unsigned FLD_LVL         = 9;
    localparam int unsigned FLD_POL         = 10;
    localparam int unsigned FLD_DB          = 11;
    localparam int unsigned FLD_PU          = 12;
    localparam int unsigned FLD_PD          = 13;
    localparam int unsigned FLD_OD          = 14;
    // status / mask layout: [1:0] pin rise+fall, [9:2] dsp flags, [11:10] ram ready
    localparam int unsigned IRQ_W           = 12;
    localparam int unsigned IRQ_DSP_LO      = 2;
    localparam int unsigned IRQ_RAM_LO      = 10;
    // function codes
    localparam logic [6:0] FN_LEVEL         = 7'h01;
    localparam logic [6:0] FN_PRIMARY_INTERRUPT_REQUEST          = 7'h02;
    localparam logic [6:0] FN_SECONDARY_INTERRUPT_REQUEST          = 7'h03;
    localparam logic [6:0] FN_DSP_FIRST     = 7'h35;
    localparam logic [6:0] FN_DSP_LAST      = 7'h3c;
    localparam logic [6:0] FN_RAM1          = 7'h46;
    localparam logic [6:0] FN_RAM2          = 7'h47;
    // reset values: input direction, level function, de-bounce field 2 (count threshold 4, level accepted on the 5th slow tick)
    localparam logic [15:0] RST_PIN_CFG     = 16'h0101;
    localparam logic [3:0]  RST_DBTIME      = 4'h2;
    localparam logic [IRQ_W-1:0] RST_MASK   = 12'hfff;
endpackage

// File: core/gpfc_top.sv
// two general-purpose pins with function select, de-bounce, edge interrupts and status outputs
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// Operation
// - each pin follows its own function field; direction set by software to match
// - input with code 01h reads pin level, polarity ignored
// - reported input level is taken after the de-bounce stage
// - per-pin de-bounce enable, 32kHz timed, shared duration field
// - input pins raise interrupt events on rising and falling edges
// - pin interrupt bits stay latched and can drive the request outputs
// - pull-up and pull-down independent; both set disables both
// - output with code 01h drives the written level field
// - level field of an output pin reads as write-only
// - polarity bit inverts any output function
// - per-pin choice of push-pull or open-drain driver
// - de-bounced edges of an input pin with code 01h trigger the write sequencer, rising and falling separately
// - codes 02h and 03h put primary or secondary request on the pin
// - primary request always present on the dedicated interrupt pin
// - each interrupt source is maskable per request output
// - codes 35h-3Ch output DSP flags; 46h and 47h the RAM flags
// - rising edges of DSP flags and RAM-ready flags raise latched events
module gpfc_top #(
    parameter int unsigned NPINS = gpfc_pkg::NPINS,
    parameter int unsigned NDSP  = gpfc_pkg::NDSP
) (
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    input  wire logic [3:0]        addr_in,
    input  wire logic [15:0]       wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [15:0]       rdata_out,
    input  wire logic [NPINS-1:0]  pin_in,
    output logic      [NPINS-1:0]  pin_out,
    output logic      [NPINS-1:0]  pin_oe_out,
    output logic      [NPINS-1:0]  pull_up_out,
    output logic      [NPINS-1:0]  pull_down_out,
    input  wire logic [NDSP-1:0]   dsp_status_flag_in,
    input  wire logic [1:0]        dsp_ram_ready_in,
    output logic                   irq_pin_out,
    output logic                   secondary_irq_out,
    output logic      [NPINS-1:0]  seq_rise_trig_out,
    output logic      [NPINS-1:0]  seq_fall_trig_out
);
    localparam int unsigned IW = gpfc_pkg::IRQ_W;

    // ****************************************
    // register file
    // ****************************************
    logic [15:0]       cfg_reg [NPINS];
    logic [3:0]        dbtime_reg;
    logic [IW-1:0]     sts_reg;
    logic [IW-1:0]     mask1_reg;
    logic [IW-1:0]     mask2_reg;
    logic [IW-1:0]     evt;
    logic [NPINS-1:0]  clean_reg;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NPINS; i++) begin
                cfg_reg[i] <= gpfc_pkg::RST_PIN_CFG;
            end
            dbtime_reg <= gpfc_pkg::RST_DBTIME;
            mask1_reg  <= gpfc_pkg::RST_MASK;
            mask2_reg  <= gpfc_pkg::RST_MASK;
        end else if (wr_in) begin
            unique case (addr_in)
                gpfc_pkg::OFS_PIN0_CFG:  cfg_reg[0] <= {1'b0, wdata_in[14:0]};
                gpfc_pkg::OFS_PIN1_CFG:  cfg_reg[1] <= {1'b0, wdata_in[14:0]};
                gpfc_pkg::OFS_DBTIME:    dbtime_reg <= wdata_in[3:0];
                gpfc_pkg::OFS_PRIMARY_INTERRUPT_REQUEST_MASK: mask1_reg  <= wdata_in[IW-1:0];
                gpfc_pkg::OFS_SECONDARY_INTERRUPT_REQUEST_MASK: mask2_reg  <= wdata_in[IW-1:0];
                default: ;
            endcase
        end
    end

    // sticky status; a new event wins over a clearing write in the same cycle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sts_reg <= '0;
        end else begin
            sts_reg <= (sts_reg & ~((wr_in && addr_in == gpfc_pkg::OFS_IRQ_STS) ? wdata_in[IW-1:0] : '0))
                       | evt;
        end
    end

    // read mux; level bit of an output pin reads zero
    logic [15:0] rd_mux;
    always_comb begin
        rd_mux = 16'h0000;
        unique case (addr_in)
            gpfc_pkg::OFS_PIN0_CFG,
            gpfc_pkg::OFS_PIN1_CFG: begin
                rd_mux = cfg_reg[addr_in[0]];
                rd_mux[gpfc_pkg::FLD_LVL] = cfg_reg[addr_in[0]][gpfc_pkg::FLD_DIR]
                                            & clean_reg[addr_in[0]];
            end
            gpfc_pkg::OFS_DBTIME:    rd_mux = {12'h000, dbtime_reg};
            gpfc_pkg::OFS_IRQ_STS:   rd_mux = {4'h0, sts_reg};
            gpfc_pkg::OFS_PRIMARY_INTERRUPT_REQUEST_MASK: rd_mux = {4'h0, mask1_reg};
            gpfc_pkg::OFS_SECONDARY_INTERRUPT_REQUEST_MASK: rd_mux = {4'h0, mask2_reg};
            gpfc_pkg::OFS_SEQ_STS:   rd_mux = {14'h0000, clean_reg};
            default:                 rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= rd_in ? rd_mux : 16'h0000;
        end
    end

    // ****************************************
    // slow tick and input synchronisers
    // ****************************************
    logic [15:0] div_reg;
    logic        tick_reg;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_reg  <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == 16'(gpfc_pkg::SLOW_DIV - 1));
            div_reg  <= (div_reg == 16'(gpfc_pkg::SLOW_DIV - 1)) ? 16'h0000 : div_reg + 16'h0001;
        end
    end

    logic [NPINS-1:0] pin_s1_reg, pin_s2_reg;
    logic [NDSP-1:0]  dsp_s1_reg, dsp_s2_reg, dsp_d_reg;
    logic [1:0]       ram_s1_reg, ram_s2_reg, ram_d_reg;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            dsp_s1_reg <= '0;
            dsp_s2_reg <= '0;
            dsp_d_reg  <= '0;
            ram_s1_reg <= '0;
            ram_s2_reg <= '0;
            ram_d_reg  <= '0;
        end else begin
            pin_s1_reg <= pin_in;
            pin_s2_reg <= pin_s1_reg;
            dsp_s1_reg <= dsp_status_flag_in;
            dsp_s2_reg <= dsp_s1_reg;
            dsp_d_reg  <= dsp_s2_reg;
            ram_s1_reg <= dsp_ram_ready_in;
            ram_s2_reg <= ram_s1_reg;
            ram_d_reg  <= ram_s2_reg;
        end
    end

    // ****************************************
    // per-pin de-bounce, edges and drivers
    // ****************************************
    logic [NPINS-1:0] rise, fall;
    logic [NPINS-1:0] pin_evt;
    logic [NPINS-1:0] fn_val;
    logic             primary_interrupt_request_lvl, secondary_interrupt_request_lvl;

    assign primary_interrupt_request_lvl = |(sts_reg & mask1_reg);
    assign secondary_interrupt_request_lvl = |(sts_reg & mask2_reg);

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            logic [6:0]  fn;
            logic        is_in;
            logic [15:0] cnt_reg;
            logic        prev_reg;

            assign fn    = cfg_reg[g][gpfc_pkg::FLD_FN_LO +: 7];
            assign is_in = cfg_reg[g][gpfc_pkg::FLD_DIR];

            // count slow ticks while the raw level differs from the accepted level
            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    cnt_reg   <= 16'h0000;
                    clean_reg[g] <= 1'b0;
                end else if (!cfg_reg[g][gpfc_pkg::FLD_DB]) begin
                    cnt_reg   <= 16'h0000;
                    clean_reg[g] <= pin_s2_reg[g];
                end else if (pin_s2_reg[g] == clean_reg[g]) begin
                    cnt_reg   <= 16'h0000;
                end else if (tick_reg) begin
                    if (cnt_reg >= (16'h0001 << dbtime_reg)) begin
                        clean_reg[g] <= pin_s2_reg[g];
                        cnt_reg   <= 16'h0000;
                    end else begin
                        cnt_reg   <= cnt_reg + 16'h0001;
                    end
                end
            end

            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    prev_reg <= 1'b0;
                end else begin
                    prev_reg <= clean_reg[g];
                end
            end

            assign rise[g]    = is_in & clean_reg[g] & ~prev_reg;
            assign fall[g]    = is_in & ~clean_reg[g] & prev_reg;
            assign pin_evt[g] = rise[g] | fall[g];

            always_comb begin
                fn_val[g] = 1'b0;
                if (fn == gpfc_pkg::FN_LEVEL) begin
                    fn_val[g] = cfg_reg[g][gpfc_pkg::FLD_LVL];
                end else if (fn == gpfc_pkg::FN_PRIMARY_INTERRUPT_REQUEST) begin
                    fn_val[g] = primary_interrupt_request_lvl;
                end else if (fn == gpfc_pkg::FN_SECONDARY_INTERRUPT_REQUEST) begin
                    fn_val[g] = secondary_interrupt_request_lvl;
                end else if (fn >= gpfc_pkg::FN_DSP_FIRST && fn <= gpfc_pkg::FN_DSP_LAST) begin
                    fn_val[g] = dsp_s2_reg[3'(fn - gpfc_pkg::FN_DSP_FIRST)];
                end else if (fn == gpfc_pkg::FN_RAM1 || fn == gpfc_pkg::FN_RAM2) begin
                    fn_val[g] = ram_s2_reg[fn[0]];
                end
            end

            always_ff @(posedge clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    pin_out[g]       <= 1'b0;
                    pin_oe_out[g]    <= 1'b0;
                    pull_up_out[g]   <= 1'b0;
                    pull_down_out[g] <= 1'b0;
                    seq_rise_trig_out[g] <= 1'b0;
                    seq_fall_trig_out[g] <= 1'b0;
                end else begin
                    // open drain only pulls low; a high level releases the pin
                    pin_out[g]    <= fn_val[g] ^ cfg_reg[g][gpfc_pkg::FLD_POL];
                    pin_oe_out[g] <= ~is_in & (~cfg_reg[g][gpfc_pkg::FLD_OD]
                                     | ~(fn_val[g] ^ cfg_reg[g][gpfc_pkg::FLD_POL]));
                    pull_up_out[g]   <= cfg_reg[g][gpfc_pkg::FLD_PU] & ~cfg_reg[g][gpfc_pkg::FLD_PD];
                    pull_down_out[g] <= cfg_reg[g][gpfc_pkg::FLD_PD] & ~cfg_reg[g][gpfc_pkg::FLD_PU];
                    seq_rise_trig_out[g] <= rise[g] & (fn == gpfc_pkg::FN_LEVEL);
                    seq_fall_trig_out[g] <= fall[g] & (fn == gpfc_pkg::FN_LEVEL);
                end
            end
        end
    endgenerate

    assign evt = {ram_s2_reg & ~ram_d_reg, dsp_s2_reg & ~dsp_d_reg, pin_evt};

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_pin_out       <= 1'b0;
            secondary_irq_out <= 1'b0;
        end else begin
            irq_pin_out       <= primary_interrupt_request_lvl;
            secondary_irq_out <= secondary_interrupt_request_lvl;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_sticky;
        @(posedge clk_in) disable iff (!nrst_in)
        (sts_reg[0] && !(wr_in && addr_in == gpfc_pkg::OFS_IRQ_STS)) |=> sts_reg[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("pin status bit lost");

    property p_pin_evt;
        @(posedge clk_in) disable iff (!nrst_in)
        pin_evt[0] |=> sts_reg[0];
    endproperty
    a_pin_evt: assert property (p_pin_evt) else $error("pin edge not latched");

    property p_dsp_rise;
        @(posedge clk_in) disable iff (!nrst_in)
        (dsp_s2_reg[0] && !dsp_d_reg[0]) |=> sts_reg[gpfc_pkg::IRQ_DSP_LO];
    endproperty
    a_dsp_rise: assert property (p_dsp_rise) else $error("dsp flag edge not latched");

    property p_irq_pin;
        @(posedge clk_in) disable iff (!nrst_in)
        |(sts_reg & mask1_reg) |=> irq_pin_out;
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq pin not raised");

    property p_mask;
        @(posedge clk_in) disable iff (!nrst_in)
        ((sts_reg & mask1_reg) == '0) |=> !irq_pin_out;
    endproperty
    a_mask: assert property (p_mask) else $error("masked source drove irq");

    property p_pulls;
        @(posedge clk_in) disable iff (!nrst_in)
        (cfg_reg[0][gpfc_pkg::FLD_PU] && cfg_reg[0][gpfc_pkg::FLD_PD]) |=> (!pull_up_out[0] && !pull_down_out[0]);
    endproperty
    a_pulls: assert property (p_pulls) else $error("both pulls active");

    property p_level_out;
        @(posedge clk_in) disable iff (!nrst_in)
        (!cfg_reg[0][gpfc_pkg::FLD_DIR] && !cfg_reg[0][gpfc_pkg::FLD_OD] && g_pin[0].fn == gpfc_pkg::FN_LEVEL)
        |=> (pin_oe_out[0] && pin_out[0] == ($past(cfg_reg[0][gpfc_pkg::FLD_LVL]) ^ $past(cfg_reg[0][gpfc_pkg::FLD_POL])));
    endproperty
    a_level_out: assert property (p_level_out) else $error("level output wrong");

    property p_wo_read;
        @(posedge clk_in) disable iff (!nrst_in)
        (rd_in && addr_in == gpfc_pkg::OFS_PIN0_CFG && !cfg_reg[0][gpfc_pkg::FLD_DIR])
        |=> !rdata_out[gpfc_pkg::FLD_LVL];
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("output level readable");

    property p_db_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        (cfg_reg[0][gpfc_pkg::FLD_DB] && !tick_reg && $stable(cfg_reg[0])) |=> $stable(clean_reg[0]);
    endproperty
    a_db_hold: assert property (p_db_hold) else $error("debounced level moved off tick");

    sequence s_clean0_rise;
        !clean_reg[0] ##1 clean_reg[0];
    endsequence

    sequence s_clean0_fall;
        clean_reg[0] ##1 !clean_reg[0];
    endsequence

    sequence s_pin0_lvl_in;
        g_pin[0].is_in && g_pin[0].fn == gpfc_pkg::FN_LEVEL;
    endsequence

    property p_seq_rise;
        @(posedge clk_in) disable iff (!nrst_in)
        (s_clean0_rise ##0 s_pin0_lvl_in) |=> seq_rise_trig_out[0];
    endproperty
    a_seq_rise: assert property (p_seq_rise) else $error("sequencer rise trigger missing");

    property p_seq_fall;
        @(posedge clk_in) disable iff (!nrst_in)
        (s_clean0_fall ##0 s_pin0_lvl_in) |=> seq_fall_trig_out[0];
    endproperty
    a_seq_fall: assert property (p_seq_fall) else $error("sequencer fall trigger missing");

    property p_fall_evt;
        @(posedge clk_in) disable iff (!nrst_in)
        (s_clean0_fall ##0 g_pin[0].is_in) |=> sts_reg[0];
    endproperty
    a_fall_evt: assert property (p_fall_evt) else $error("pin falling edge not latched");

    property p_out_quiet;
        @(posedge clk_in) disable iff (!nrst_in)
        (!g_pin[0].is_in && !sts_reg[0]) |=> !sts_reg[0];
    endproperty
    a_out_quiet: assert property (p_out_quiet) else $error("output pin raised an edge event");

    property p_db_off;
        @(posedge clk_in) disable iff (!nrst_in)
        !cfg_reg[0][gpfc_pkg::FLD_DB] |=> (clean_reg[0] == $past(pin_s2_reg[0]));
    endproperty
    a_db_off: assert property (p_db_off) else $error("level without de-bounce not followed");

    property p_ram_rise;
        @(posedge clk_in) disable iff (!nrst_in)
        (ram_s2_reg[1] && !ram_d_reg[1]) |=> sts_reg[gpfc_pkg::IRQ_RAM_LO + 1];
    endproperty
    a_ram_rise: assert property (p_ram_rise) else $error("ram ready edge not latched");

    property p_secondary_interrupt_request;
        @(posedge clk_in) disable iff (!nrst_in)
        |(sts_reg & mask2_reg) |=> secondary_irq_out;
    endproperty
    a_secondary_interrupt_request: assert property (p_secondary_interrupt_request) else $error("secondary request not raised");

    property p_secondary_interrupt_request_route;
        @(posedge clk_in) disable iff (!nrst_in)
        (g_pin[1].fn == gpfc_pkg::FN_SECONDARY_INTERRUPT_REQUEST && !cfg_reg[1][gpfc_pkg::FLD_POL]) |=> pin_out[1] == $past(secondary_interrupt_request_lvl);
    endproperty
    a_secondary_interrupt_request_route: assert property (p_secondary_interrupt_request_route) else $error("secondary request not routed");

    property p_od;
        @(posedge clk_in) disable iff (!nrst_in)
        (!cfg_reg[0][gpfc_pkg::FLD_DIR] && cfg_reg[0][gpfc_pkg::FLD_OD]) |=> (pin_oe_out[0] == !pin_out[0]);
    endproperty
    a_od: assert property (p_od) else $error("open drain drove a high level");

    property p_dsp_route;
        @(posedge clk_in) disable iff (!nrst_in)
        (g_pin[0].fn == gpfc_pkg::FN_DSP_FIRST && !cfg_reg[0][gpfc_pkg::FLD_POL])
        |=> pin_out[0] == $past(dsp_s2_reg[0]);
    endproperty
    a_dsp_route: assert property (p_dsp_route) else $error("dsp flag not routed");
endmodule

// File: verification/gpfc_pin_model.sv
// external pin model: logic drivers, resistors and a floating wire
`timescale 1ns/100ps
module gpfc_pin_model (
    input  wire logic       clk_in,
    input  wire logic [1:0] ext_en_in,
    input  wire logic [1:0] ext_val_in,
    input  wire logic [1:0] pin_out_in,
    input  wire logic [1:0] pin_oe_in,
    input  wire logic [1:0] pu_in,
    input  wire logic [1:0] pd_in,
    output logic      [1:0] lvl_out
);
    logic [1:0] last_reg;
    // a released pin with no resistor shows the inverse of its last driven level
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe_in[i] | ext_en_in[i] | pu_in[i] | pd_in[i]) last_reg[i] <= lvl_out[i];
        end
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (pin_oe_in[i]) lvl_out[i] = pin_out_in[i];
            else if (ext_en_in[i]) lvl_out[i] = ext_val_in[i];
            else if (pu_in[i]) lvl_out[i] = 1'b1;
            else if (pd_in[i]) lvl_out[i] = 1'b0;
            else lvl_out[i] = ~last_reg[i];
        end
    end
endmodule

// File: verification/gpfc_top_tb_top.sv
// self-checking bench for the two-pin function control block
`timescale 1ns/100ps
module gpfc_top_tb_top;
    logic        clk_in, nrst_in, wr_in, rd_in, irq_pin_out, secondary_irq_out;
    logic [3:0]  addr_in;
    logic [15:0] wdata_in, rdata_out, rv;
    logic [1:0]  pin_in, pin_out, pin_oe_out, pull_up_out, pull_down_out, ext_en, ext_val;
    logic [1:0]  seq_rise_trig_out, seq_fall_trig_out, ram_in;
    logic [7:0]  dsp_in;
    int          fail_count, tests_run, rise_cnt, fall_cnt;
    gpfc_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .pull_up_out(pull_up_out), .pull_down_out(pull_down_out), .dsp_status_flag_in(dsp_in),
        .dsp_ram_ready_in(ram_in), .irq_pin_out(irq_pin_out), .secondary_irq_out(secondary_irq_out),
        .seq_rise_trig_out(seq_rise_trig_out), .seq_fall_trig_out(seq_fall_trig_out));
    gpfc_pin_model pins (.clk_in(clk_in), .ext_en_in(ext_en), .ext_val_in(ext_val), .pin_out_in(pin_out),
        .pin_oe_in(pin_oe_out), .pu_in(pull_up_out), .pd_in(pull_down_out), .lvl_out(pin_in));
    // ************
    // helpers
    // ************
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        rise_cnt += (seq_rise_trig_out[0] === 1'b1);
        fall_cnt += (seq_fall_trig_out[0] === 1'b1);
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1; addr_in <= a; wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_in);
        rd_in <= 1'b1; addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [3:0] a, input logic [15:0] e);
        rd(a);
        chk(nm, e, rv);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ************
    // scenarios
    // ************
    task automatic t_reset;
        rchk("cfg0", gpfc_pkg::OFS_PIN0_CFG, 16'h0101);
        rchk("dbtime", gpfc_pkg::OFS_DBTIME, 16'h0002);
        rchk("mask1", gpfc_pkg::OFS_PRIMARY_INTERRUPT_REQUEST_MASK, 16'h0fff);
        rchk("status", gpfc_pkg::OFS_IRQ_STS, 16'h0000);
        rchk("unmapped", 4'hf, 16'h0000);
    endtask
    task automatic t_input;
        wr(gpfc_pkg::OFS_PIN0_CFG, 16'h0501);
        ext_val[0] <= 1'b1;
        cyc(8);
        rchk("level", gpfc_pkg::OFS_PIN0_CFG, 16'h0701);
        rchk("sts rise", gpfc_pkg::OFS_IRQ_STS, 16'h0001);
        chk("irq", 16'h1, {15'h0, irq_pin_out});
        chk("rise trig", 16'h1, 16'(rise_cnt));
        cyc(20);
        rchk("latched", gpfc_pkg::OFS_IRQ_STS, 16'h0001);
        wr(gpfc_pkg::OFS_IRQ_STS, 16'h0001);
        cyc(2);
        rchk("cleared", gpfc_pkg::OFS_IRQ_STS, 16'h0000);
        chk("irq low", 16'h0, {15'h0, irq_pin_out});
        ext_val[0] <= 1'b0;
        cyc(8);
        rchk("sts fall", gpfc_pkg::OFS_IRQ_STS, 16'h0001);
        chk("fall trig", 16'h1, 16'(fall_cnt));
        wr(gpfc_pkg::OFS_PRIMARY_INTERRUPT_REQUEST_MASK, 16'h0000);
        cyc(3);
        chk("masked", 16'h0, {15'h0, irq_pin_out});
        chk("secondary_interrupt_request", 16'h1, {15'h0, secondary_irq_out});
        wr(gpfc_pkg::OFS_PRIMARY_INTERRUPT_REQUEST_MASK, 16'h0fff);
        wr(gpfc_pkg::OFS_IRQ_STS, 16'h0fff);
    endtask
    task automatic t_output;
        ext_en <= 2'b10;
        wr(gpfc_pkg::OFS_PIN0_CFG, 16'h0201);
        cyc(3);
        chk("drive", 16'h3, {14'h0, pin_oe_out[0], pin_in[0]});
        rchk("wonly", gpfc_pkg::OFS_PIN0_CFG, 16'h0001);
        wr(gpfc_pkg::OFS_PIN0_CFG, 16'h0601);
        cyc(3);
        chk("invert", 16'h2, {14'h0, pin_oe_out[0], pin_in[0]});
        wr(gpfc_pkg::OFS_PIN0_CFG, 16'h4201);
        cyc(3);
        chk("od high", 16'h0, {15'h0, pin_oe_out[0]});
        wr(gpfc_pkg::OFS_PIN0_CFG, 16'h4001);
        cyc(3);
        chk("od low", 16'h2, {14'h0, pin_oe_out[0], pin_out[0]});
        rchk("no evt", gpfc_pkg::OFS_IRQ_STS, 16'h0000);
    endtask
    task automatic t_pulls;
        logic [15:0] cf [3] = '{16'h1101, 16'h2101, 16'h3101};
        logic [15:0] ex [3] = '{16'h2, 16'h1, 16'h0};
        for (int i = 0; i < 3; i++) begin
            wr(gpfc_pkg::OFS_PIN1_CFG, cf[i]);
            cyc(3);
            chk("pulls", ex[i], {14'h0, pull_up_out[1], pull_down_out[1]});
        end
        wr(gpfc_pkg::OFS_PIN1_CFG, 16'h0101);
    endtask
    task automatic t_dsp;
        dsp_in <= 8'hff;
        ram_in <= 2'h3;
        cyc(8);
        rchk("dsp sts", gpfc_pkg::OFS_IRQ_STS, 16'h0ffc);
        for (int k = 0; k < 10; k++) begin
            dsp_in <= (k < 8) ? 8'h01 << k : 8'h00;
            ram_in <= (k == 8) ? 2'h1 : (k == 9) ? 2'h2 : 2'h0;
            wr(gpfc_pkg::OFS_PIN0_CFG, (k < 8) ? 16'(gpfc_pkg::FN_DSP_FIRST + k) : 16'(gpfc_pkg::FN_RAM1 + k - 8));
            cyc(4);
            chk("flag on", 16'h1, {15'h0, pin_out[0]});
            dsp_in <= ~dsp_in;
            ram_in <= ~ram_in;
            cyc(4);
            chk("flag off", 16'h0, {15'h0, pin_out[0]});
        end
    endtask
    task automatic t_irq_route;
        wr(gpfc_pkg::OFS_SECONDARY_INTERRUPT_REQUEST_MASK, 16'h0000);
        wr(gpfc_pkg::OFS_PIN1_CFG, 16'h0002);
        cyc(4);
        chk("primary_interrupt_request pin", 16'h3, {14'h0, pin_out[1], irq_pin_out});
        wr(gpfc_pkg::OFS_PIN1_CFG, 16'h0003);
        cyc(4);
        chk("secondary_interrupt_request pin", 16'h1, {14'h0, pin_out[1], irq_pin_out});
        wr(gpfc_pkg::OFS_PIN1_CFG, 16'h0403);
        cyc(4);
        chk("secondary_interrupt_request inv", 16'h2, {14'h0, pin_out[1], secondary_irq_out});
        wr(gpfc_pkg::OFS_PIN1_CFG, 16'h0101);
        wr(gpfc_pkg::OFS_SECONDARY_INTERRUPT_REQUEST_MASK, 16'h0fff);
    endtask
    task automatic t_debounce;
        ext_en <= 2'b11;
        ext_val <= 2'b00;
        wr(gpfc_pkg::OFS_DBTIME, 16'h0000);
        wr(gpfc_pkg::OFS_PIN0_CFG, 16'h0901);
        cyc(3000);
        wr(gpfc_pkg::OFS_IRQ_STS, 16'h0fff);
        ext_val[0] <= 1'b1;
        cyc(300);
        ext_val[0] <= 1'b0;
        cyc(3000);
        rchk("glitch", gpfc_pkg::OFS_IRQ_STS, 16'h0000);
        ext_val[0] <= 1'b1;
        cyc(400);
        rchk("early", gpfc_pkg::OFS_IRQ_STS, 16'h0000);
        cyc(2600);
        rchk("settled", gpfc_pkg::OFS_IRQ_STS, 16'h0001);
        rchk("db level", gpfc_pkg::OFS_PIN0_CFG, 16'h0b01);
    endtask
    // ************
    // main sequence
    // ************
    initial begin
        nrst_in = 1'b0; wr_in = 1'b0; rd_in = 1'b0; addr_in = 4'h0; wdata_in = 16'h0000;
        ext_en = 2'b11; ext_val = 2'b00; dsp_in = 8'h00; ram_in = 2'h0;
        fail_count = 0; tests_run = 0; rise_cnt = 0; fall_cnt = 0;
        cyc(8);
        nrst_in <= 1'b1;
        t_reset();
        t_input();
        t_output();
        t_pulls();
        t_dsp();
        // flags end high; drop them so the next raise is a real rising edge
        dsp_in <= 8'h00;
        cyc(4);
        wr(gpfc_pkg::OFS_IRQ_STS, 16'h0fff);
        dsp_in <= 8'h01;
        cyc(8);
        t_irq_route();
        t_debounce();
        report_and_stop();
    end
    // whole run is about 9600 cycles; give it about four times that
    initial begin
        cyc(40000);
        fail_count++;
        report_and_stop();
    end
endmodule
